// ==== hdl/cpcfg_top.sv ====
// Codec port bit clock, frame sync, slot and byte order logic
// Function
// - Frame sync lasts slot zero or one
// - Byte swap reverses bytes of each sample
// - Bit clock pin input when direction set
// - Frame sync pin input when direction set
// - AC97: address in slot, data next
// - Other modes: address, data same slot
// - Source select picks divide-by-I or divide-by-M
// - Divider code zero off, else N+1
// - Slot zero length code 8/16/32, code zero follows the ordinary slot length
`default_nettype none
module cpcfg_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Source ticks from divide-by-M and divide-by-I stages
  input wire logic div_m_tick,
  input wire logic div_i_tick,
  // Mode from the port mode register
  input wire logic ac97_mode,
  // Bit clock pin
  input wire logic port_bit_clock_i,
  output logic port_bit_clock_o,
  output logic port_bit_clock_oe,
  // Frame sync pin
  input wire logic port_frame_sync_i,
  output logic port_frame_sync_o,
  output logic port_frame_sync_oe,
  // Slot markers for secondary words
  output logic sec_addr_slot,
  output logic sec_data_slot,
  // DMA sample path
  input wire cpcfg_pkg::cpcfg_sample_t dma_in,
  output cpcfg_pkg::cpcfg_sample_t dma_out
);
  import cpcfg_pkg::*;

  logic [7:0] cfg4_r;
  logic [7:0] cfg3_r;
  logic [7:0] cfg2_r;
  logic [7:0] rdata_r;
  cpcfg_cfg_t cfg;
  logic bclk_s1_r, bclk_s2_r, bclk_s3_r;
  logic fs_s1_r, fs_s2_r, fs_s3_r;
  logic [2:0] div_cnt_r;
  logic [2:0] div_cnt_nxt;
  logic bclk_gen_r;
  logic div_rise;
  logic src_tick;
  logic bclk_rise;
  logic fs_rise;
  logic [5:0] bit_cnt_r, bit_cnt_nxt;
  logic [3:0] slot_r, slot_nxt;
  logic [5:0] cur_len;
  logic fs_out_r, fs_oe_r, bclk_oe_r;
  logic sec_addr_r, sec_data_r;
  cpcfg_sample_t dma_r;

  // Length of the ordinary slots, in bit clocks
  function automatic logic [5:0] slot_len_f(input logic [2:0] code);
    case (code)
      3'h0: slot_len_f = 6'h08;
      3'h1: slot_len_f = 6'h10;
      3'h2: slot_len_f = 6'h12;
      3'h3: slot_len_f = 6'h14;
      3'h4: slot_len_f = 6'h18;
      3'h5: slot_len_f = 6'h20;
      default: slot_len_f = 6'h08; // Reserved codes fall back to 8
    endcase
  endfunction : slot_len_f

  // Length of slot zero
  function automatic logic [5:0] slot0_len_f(input logic [1:0] code,
                                             input logic [2:0] other);
    case (code)
      2'h1: slot0_len_f = 6'h08;
      2'h2: slot0_len_f = 6'h10;
      2'h3: slot0_len_f = 6'h20;
      default: slot0_len_f = slot_len_f(other);
    endcase
  endfunction : slot0_len_f

  // Reverse the used bytes of a sample, upper bytes zero for 2 or 3 bytes
  function automatic logic [31:0] swap_f(input logic [31:0] d,
                                         input logic [1:0] n);
    case (n)
      CPCFG_BYTES_2: swap_f = {16'h0000, d[7:0], d[15:8]};
      CPCFG_BYTES_3: swap_f = {8'h00, d[7:0], d[15:8], d[23:16]};
      CPCFG_BYTES_4: swap_f = {d[7:0], d[15:8], d[23:16], d[31:24]};
      default: swap_f = d; // One byte has no order to reverse
    endcase
  endfunction : swap_f

  // Field view of the stored registers
  always_comb begin
    cfg.secondary_slot_select = cfg4_r[CPCFG_SLOT_SEL_LSB +: 4];
    cfg.divider_source_sel = cfg4_r[CPCFG_SRC_SEL_BIT];
    cfg.bit_clock_divide = cfg4_r[CPCFG_DIV_LSB +: 3];
    cfg.frame_sync_length_sel = cfg3_r[CPCFG_FS_LEN_BIT];
    cfg.sample_byte_swap = cfg3_r[CPCFG_SWAP_BIT];
    cfg.bit_clock_dir = cfg3_r[CPCFG_BCLK_DIR_BIT];
    cfg.frame_sync_dir = cfg3_r[CPCFG_FS_DIR_BIT];
    cfg.slot_zero_length = cfg2_r[CPCFG_SLOT0_LSB +: 2];
    cfg.slot_length = cfg2_r[CPCFG_SLOTLEN_LSB +: 3];
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg4_r <= CPCFG_RST_CFG4;
      cfg3_r <= CPCFG_RST_CFG3;
      cfg2_r <= CPCFG_RST_CFG2;
    end else if (reg_wr) begin
      if (reg_addr == CPCFG_ADDR_CFG4) cfg4_r <= reg_wdata;
      if (reg_addr == CPCFG_ADDR_CFG3) cfg3_r <= {4'h0, reg_wdata[3:0]};
      if (reg_addr == CPCFG_ADDR_CFG2) cfg2_r <= {reg_wdata[7:6], 3'h0,
                                                  reg_wdata[2:0]};
    end
  end

  // Read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        CPCFG_ADDR_CFG4: rdata_r <= cfg4_r;
        CPCFG_ADDR_CFG3: rdata_r <= cfg3_r;
        CPCFG_ADDR_CFG2: rdata_r <= cfg2_r;
        CPCFG_ADDR_STAT: rdata_r <= {slot_r, 2'h0, fs_out_r, bclk_gen_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // Pin synchronisers; stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
      fs_s1_r <= 1'b0;
      fs_s2_r <= 1'b0;
      fs_s3_r <= 1'b0;
    end else begin
      bclk_s1_r <= port_bit_clock_i;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
      fs_s1_r <= port_frame_sync_i;
      fs_s2_r <= fs_s1_r;
      fs_s3_r <= fs_s2_r;
    end
  end

  // Divider source and next count
  always_comb begin
    src_tick = cfg.divider_source_sel ? div_i_tick : div_m_tick;
    div_cnt_nxt = div_cnt_r;
    if (cfg.bit_clock_divide == CPCFG_DIV_OFF) begin
      div_cnt_nxt = 3'h0;
    end else if (src_tick || (div_cnt_r > cfg.bit_clock_divide)) begin
      // Wrap at the code; a count left above a lowered code wraps at once
      div_cnt_nxt = (div_cnt_r >= cfg.bit_clock_divide) ? 3'h0 :
                    3'(div_cnt_r + 3'h1);
    end
  end
  assign div_rise = src_tick && (cfg.bit_clock_divide != CPCFG_DIV_OFF) &&
                    (div_cnt_nxt == 3'h0);

  // Generated bit clock, high in the first half of each period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_r <= 3'h0;
      bclk_gen_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      if (cfg.bit_clock_divide == CPCFG_DIV_OFF) begin
        bclk_gen_r <= 1'b0;
      end else if (src_tick) begin
        bclk_gen_r <= {1'b0, div_cnt_nxt} <
                      4'(({1'b0, cfg.bit_clock_divide} + 4'h1) >> 1);
      end
    end
  end

  // Bit clock edge from the pin or the divider
  assign bclk_rise = cfg.bit_clock_dir ? (bclk_s2_r && !bclk_s3_r) :
                     div_rise;
  assign fs_rise = cfg.frame_sync_dir && fs_s2_r && !fs_s3_r;
  assign cur_len = (slot_r == 4'h0) ?
                   slot0_len_f(cfg.slot_zero_length, cfg.slot_length) :
                   slot_len_f(cfg.slot_length);

  // Next frame position; an incoming sync restarts the frame
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    slot_nxt = slot_r;
    if (fs_rise) begin
      bit_cnt_nxt = 6'h00;
      slot_nxt = 4'h0;
    end else if (bclk_rise) begin
      if (bit_cnt_r >= 6'(cur_len - 6'h01)) begin
        bit_cnt_nxt = 6'h00;
        slot_nxt = 4'(slot_r + 4'h1);
      end else begin
        bit_cnt_nxt = 6'(bit_cnt_r + 6'h01);
      end
    end
  end

  // Frame position counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt_r <= 6'h00;
      slot_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      slot_r <= slot_nxt;
    end
  end

  // Frame sync driven only when it is an output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fs_out_r <= 1'b0;
    end else if (cfg.frame_sync_dir) begin
      fs_out_r <= 1'b0;
    end else if (bclk_rise) begin
      fs_out_r <= (slot_nxt == 4'h0) &&
                  (cfg.frame_sync_length_sel || bit_cnt_nxt == 6'h00);
    end
  end

  // Pin enables follow the direction bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bclk_oe_r <= 1'b1;
      fs_oe_r <= 1'b1;
    end else begin
      bclk_oe_r <= !cfg.bit_clock_dir;
      fs_oe_r <= !cfg.frame_sync_dir;
    end
  end
  assign port_bit_clock_o = bclk_gen_r;
  assign port_bit_clock_oe = bclk_oe_r;
  assign port_frame_sync_o = fs_out_r;
  assign port_frame_sync_oe = fs_oe_r;

  // Secondary slot markers; AC97 puts the data one slot later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_addr_r <= 1'b0;
      sec_data_r <= 1'b0;
    end else begin
      sec_addr_r <= slot_r == cfg.secondary_slot_select;
      sec_data_r <= ac97_mode ?
                    (slot_r == 4'(cfg.secondary_slot_select + 4'h1)) :
                    (slot_r == cfg.secondary_slot_select);
    end
  end
  assign sec_addr_slot = sec_addr_r;
  assign sec_data_slot = sec_data_r;

  // Byte order stage, one cycle of latency either way
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_r <= '0;
    end else begin
      dma_r.valid <= dma_in.valid;
      dma_r.nbytes <= dma_in.nbytes;
      dma_r.data <= cfg.sample_byte_swap ?
                    swap_f(dma_in.data, dma_in.nbytes) : dma_in.data;
    end
  end
  assign dma_out = dma_r;

  // Checks
  sequence s_short_sync;
    bclk_rise && fs_out_r && !cfg.frame_sync_length_sel &&
    !cfg.frame_sync_dir && !fs_rise;
  endsequence
  sequence s_swap4;
    dma_in.valid && cfg.sample_byte_swap && dma_in.nbytes == CPCFG_BYTES_4;
  endsequence

  a_sync_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    s_short_sync |=> !fs_out_r) else $error("sync longer than one");
  a_sync_in_slot0: assert property (@(posedge clk) disable iff (!rst_n)
    fs_out_r |-> slot_r == 4'h0) else $error("sync outside slot 0");
  a_swap_four: assert property (@(posedge clk) disable iff (!rst_n)
    s_swap4 |=> dma_out.data[7:0] == $past(dma_in.data[31:24]) &&
    dma_out.data[31:24] == $past(dma_in.data[7:0]))
    else $error("bytes not reversed");
  a_pass_through: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.sample_byte_swap |=> dma_out.data == $past(dma_in.data))
    else $error("sample changed");
  a_bclk_input: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.bit_clock_dir [*2] |-> !port_bit_clock_oe)
    else $error("bit clock driven as input");
  a_fs_input: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.frame_sync_dir [*2] |-> !port_frame_sync_oe && !port_frame_sync_o)
    else $error("frame sync driven as input");
  a_sec_addr_slot: assert property (@(posedge clk) disable iff (!rst_n)
    sec_addr_slot |-> $past(slot_r) == $past(cfg.secondary_slot_select))
    else $error("address slot wrong");
  a_ac97_data: assert property (@(posedge clk) disable iff (!rst_n)
    $past(ac97_mode) && sec_data_slot |->
    $past(slot_r) == 4'($past(cfg.secondary_slot_select) + 4'h1))
    else $error("data slot wrong");
  a_same_slot: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(ac97_mode) |-> sec_data_slot == sec_addr_slot)
    else $error("data slot differs");
  a_src_gate: assert property (@(posedge clk) disable iff (!rst_n)
    div_rise |-> (cfg.divider_source_sel ? div_i_tick : div_m_tick))
    else $error("edge from wrong source");
  a_div_bound: assert property (@(posedge clk) disable iff (!rst_n)
    div_cnt_r <= cfg.bit_clock_divide || $changed(cfg.bit_clock_divide) ||
    $past(cfg.bit_clock_divide) != cfg.bit_clock_divide)
    else $error("divider count out of range");
  a_off_no_edge: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.bit_clock_divide == CPCFG_DIV_OFF [*2] |-> !port_bit_clock_o &&
    !div_rise) else $error("edge while divider off");
  a_slot0_len: assert property (@(posedge clk) disable iff (!rst_n)
    bclk_rise && !fs_rise && slot_r == 4'h0 && cfg.slot_zero_length == 2'h1
    && bit_cnt_r == 6'h07 |=> slot_r == 4'h1)
    else $error("slot zero length wrong");
endmodule : cpcfg_top
`default_nettype wire

// ==== hdl/cpcfg_pkg.sv ====
// Package for the codec port clock and frame configuration block
`default_nettype none
package cpcfg_pkg;
  // Register byte addresses
  localparam logic [15:0] CPCFG_ADDR_CFG4 = 16'hFFDD;
  localparam logic [15:0] CPCFG_ADDR_CFG3 = 16'hFFDE;
  localparam logic [15:0] CPCFG_ADDR_CFG2 = 16'hFFDF;
  localparam logic [15:0] CPCFG_ADDR_STAT = 16'hFFE0;
  // Reset values
  localparam logic [7:0] CPCFG_RST_CFG4 = 8'h00;
  localparam logic [7:0] CPCFG_RST_CFG3 = 8'h00;
  localparam logic [7:0] CPCFG_RST_CFG2 = 8'h00;
  // Field positions
  localparam int CPCFG_SLOT_SEL_LSB = 4;
  localparam int CPCFG_SRC_SEL_BIT = 3;
  localparam int CPCFG_DIV_LSB = 0;
  localparam int CPCFG_FS_LEN_BIT = 3;
  localparam int CPCFG_SWAP_BIT = 2;
  localparam int CPCFG_BCLK_DIR_BIT = 1;
  localparam int CPCFG_FS_DIR_BIT = 0;
  localparam int CPCFG_SLOT0_LSB = 6;
  localparam int CPCFG_SLOTLEN_LSB = 0;
  // Divider code meaning off
  localparam logic [2:0] CPCFG_DIV_OFF = 3'h0;
  // Sample size codes: bytes minus one
  localparam logic [1:0] CPCFG_BYTES_2 = 2'h1;
  localparam logic [1:0] CPCFG_BYTES_3 = 2'h2;
  localparam logic [1:0] CPCFG_BYTES_4 = 2'h3;

  // Decoded configuration
  typedef struct packed {
    logic [3:0] secondary_slot_select;
    logic divider_source_sel;
    logic [2:0] bit_clock_divide;
    logic frame_sync_length_sel;
    logic sample_byte_swap;
    logic bit_clock_dir;
    logic frame_sync_dir;
    logic [1:0] slot_zero_length;
    logic [2:0] slot_length;
  } cpcfg_cfg_t;

  // One audio sample on the DMA path
  typedef struct packed {
    logic valid;
    logic [1:0] nbytes;
    logic [31:0] data;
  } cpcfg_sample_t;
endpackage : cpcfg_pkg
`default_nettype wire

// ==== testbench/cpcfg_codec_model.sv ====
// Behavioural external codec acting as bit clock and frame master
`default_nettype none
module cpcfg_codec_model (
  // Clock and enable
  input wire logic clk,
  input wire logic en,
  // Levels offered to the pins
  output var logic bclk = 1'h0,
  output var logic fsync = 1'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] div_r = 3'h0;
  logic [4:0] bit_r = 5'h00;
  // Eight system clocks a bit, 32 bits a frame; released lines toggle
  // so that a stale level is never mistaken for a driven one
  always @(posedge clk) begin
    div_r <= div_r + 3'h1;
    if (!en) begin
      bclk <= ~bclk;
      fsync <= ~fsync;
    end else begin
      bclk <= div_r[2];
      fsync <= (bit_r == 5'h00);
      if (div_r == 3'h7) begin
        bit_r <= bit_r + 5'h01;
      end
    end
  end
endmodule : cpcfg_codec_model
`default_nettype wire

// ==== testbench/test_codec_port_clock_frame_config.sv ====
// Self-checking bench for the codec port configuration block
`default_nettype none
module test_codec_port_clock_frame_config;
  timeunit 1ns;
  timeprecision 100ps;
  import cpcfg_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_rdata;
  logic div_m_tick = 1'h0;
  logic div_i_tick = 1'h0;
  logic ac97_mode = 1'h0;
  logic m_en = 1'h0;
  logic bc_o, bc_oe, fs_o, fs_oe, sa, sd, m_bc, m_fs;
  cpcfg_sample_t dma_in = '0;
  cpcfg_sample_t dma_out;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hC7C9E760;
  // Pin levels resolved from the block's output enables; the codec drives otherwise
  wire logic bc_w = bc_oe ? bc_o : m_bc;
  wire logic fs_w = fs_oe ? fs_o : m_fs;
  wire logic [4:0] mon = {fs_w, sd, sa, fs_o, bc_o};

  cpcfg_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .div_m_tick(div_m_tick),
    .div_i_tick(div_i_tick), .ac97_mode(ac97_mode),
    .port_bit_clock_i(bc_w), .port_bit_clock_o(bc_o),
    .port_bit_clock_oe(bc_oe), .port_frame_sync_i(fs_w),
    .port_frame_sync_o(fs_o), .port_frame_sync_oe(fs_oe),
    .sec_addr_slot(sa), .sec_data_slot(sd), .dma_in(dma_in),
    .dma_out(dma_out));
  cpcfg_codec_model u_codec (.clk(clk), .en(m_en), .bclk(m_bc),
    .fsync(m_fs));

  // 40 MHz clock
  always #12.5 clk = ~clk;
  // M ticks every cycle, I ticks every other cycle
  always @(posedge clk) begin
    div_m_tick <= 1'h1;
    div_i_tick <= ~div_i_tick;
  end
  // Hang guard, well beyond the longest sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  // Bit clocks in an ordinary slot; reserved codes act as 8
  function automatic int slen(input logic [2:0] c);
    case (c)
      3'h1: return 16;
      3'h2: return 18;
      3'h3: return 20;
      3'h4: return 24;
      3'h5: return 32;
      default: return 8;
    endcase
  endfunction : slen

  // Expected data: low nbytes+1 bytes reversed, upper bytes cleared;
  // a single byte has no order, so the whole word passes untouched
  function automatic logic [31:0] swp(input cpcfg_sample_t s,
      input logic en);
    logic [31:0] r;
    r = 32'h0;
    if (!en || s.nbytes == 2'h0) begin
      return s.data;
    end
    for (int i = 0; i <= int'(s.nbytes); i++) begin
      r[8*i +: 8] = s.data[8*(int'(s.nbytes) - i) +: 8];
    end
    return r;
  endfunction : swp

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Cycles until watched bit b changes to level v
  task automatic wedge(input int b, input logic v, output int n);
    logic p;
    n = 0;
    p = mon[b];
    forever begin
      @(posedge clk);
      #1;
      n++;
      if (mon[b] === v && p !== v) break;
      p = mon[b];
      if (n > 1200) begin
        chk(1'h0, 1'h1);
        break;
      end
    end
  endtask : wedge

  initial begin
    int n;
    int e;
    logic [7:0] d;
    logic [31:0] r;
    cpcfg_sample_t s;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk({bc_oe, fs_oe, reg_rdata}, {2'h3, 8'h00});
    // Reset values, unmapped and reserved places
    rd(CPCFG_ADDR_CFG4, d);
    chk(d, CPCFG_RST_CFG4);
    rd(16'hFFE1, d);
    chk(d, 8'h00);
    // Idle status: divider off, slot zero, no sync, no clock
    rd(CPCFG_ADDR_STAT, d);
    chk(d, 8'h00);
    wr(CPCFG_ADDR_CFG2, 8'hFF);
    rd(CPCFG_ADDR_CFG2, d);
    chk(d, 8'hC7);
    // Random slot and divider values read back, data stands one cycle
    repeat (4) begin
      r = xorshift();
      wr(CPCFG_ADDR_CFG4, r[7:0]);
      rd(CPCFG_ADDR_CFG4, d);
      chk(d, r[7:0]);
      @(posedge clk);
      #1;
      chk(reg_rdata, 8'h00);
    end
    // Every direction combination
    for (int i = 0; i < 4; i++) begin
      wr(CPCFG_ADDR_CFG3, i[7:0]);
      @(posedge clk);
      #1;
      chk({bc_oe, fs_oe}, {~i[1], ~i[0]});
    end
    wr(CPCFG_ADDR_CFG3, 8'h00);
    wr(CPCFG_ADDR_CFG2, 8'h00);
    // Bit clock period for both sources and codes 1 to 7
    for (int k = 0; k < 2; k++) begin
      for (int c = 1; c < 8; c++) begin
        wr(CPCFG_ADDR_CFG4, {4'h0, k[0], c[2:0]});
        repeat (3) wedge(0, 1'h1, n);
        chk(n, (c + 1) * (k + 1));
      end
    end
    // Divider off: no edges at all
    wr(CPCFG_ADDR_CFG4, 8'h00);
    repeat (2) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      #1;
      chk(bc_o, 1'h0);
    end
    // Frame sync length over every slot zero code
    wr(CPCFG_ADDR_CFG4, 8'h01);
    for (int z = 0; z < 8; z++) begin
      // Ordinary slot length varies too, so code 00 follows it
      wr(CPCFG_ADDR_CFG2, {z[1:0], 3'h0, z[2:0]});
      wr(CPCFG_ADDR_CFG3, {4'h0, z[2], 3'h0});
      repeat (2) wedge(1, 1'h1, n);
      wedge(1, 1'h0, n);
      e = z[2] ? (z[1:0] == 2'h0 ? 2 * slen(z[2:0]) : 8 << z[1:0]) : 2;
      chk(n, e);
    end
    wr(CPCFG_ADDR_CFG3, 8'h00);
    wr(CPCFG_ADDR_CFG2, 8'h00);
    // Secondary word slots: AC97 split, then shared slot 7
    for (int a = 1; a >= 0; a--) begin
      @(posedge clk);
      ac97_mode <= a[0];
      wr(CPCFG_ADDR_CFG4, {a[0] ? 4'h1 : 4'h7, 4'h1});
      repeat (2) wedge(1, 1'h1, n);
      wedge(2, 1'h1, n);
      chk(n, a[0] ? 17 : 113);
      if (a[0]) begin
        wedge(3, 1'h1, n);
        chk(n, 16);
      end else begin
        repeat (20) begin
          chk(sd, sa);
          @(posedge clk);
          #1;
        end
      end
    end
    // Codec drives both pins; its frame sync restarts slot counting
    @(posedge clk);
    m_en <= 1'h1;
    wr(CPCFG_ADDR_CFG4, 8'h01);
    wr(CPCFG_ADDR_CFG3, 8'h03);
    repeat (2) wedge(4, 1'h1, n);
    wedge(2, 1'h1, n);
    chk(n >= 2 && n <= 10, 1'h1);
    @(posedge clk);
    m_en <= 1'h0;
    // Random samples of every size, with and without swapping
    for (int w = 0; w < 2; w++) begin
      wr(CPCFG_ADDR_CFG3, {5'h00, w[0], 2'h0});
      repeat (24) begin
        r = xorshift();
        s = {r[4], r[1:0], xorshift()};
        @(posedge clk);
        dma_in <= s;
        @(posedge clk);
        #1;
        chk(dma_out, {s.valid, s.nbytes, swp(s, w[0])});
      end
    end
    test_done();
  end
endmodule : test_codec_port_clock_frame_config
`default_nettype wire
